/* File: bench/rcc_pin_model.sv */
// model of the board driving the external reset pin
// assumes the block's pull-up enable output and one system clock
`timescale 1ns/1ps
module rcc_pin_model (
  input  wire logic sys_clk,
  input  wire logic pull_low,
  input  wire logic pullup_en,
  output logic      pin
);
  logic last = 1'b1;

  // remember the level so a floating pin can wander
  always @(posedge sys_clk) last <= pin;

  // only the board drives low; weak pull-up or float otherwise
  assign pin = pull_low ? 1'b0 : (pullup_en ? 1'b1 : ~last);
endmodule

/* File: bench/tb_reset_control_and_cause_logic.sv */
// self-checking bench for the reset control and cause logic
// assumes rcc_pkg, the design top and the pin model are compiled first
`timescale 1ns/1ps
module tb_reset_control_and_cause_logic;
  localparam int PW = 20;
  logic sys_clk = 0, reset = 1, pull_low = 0, wake_irq = 0, sleeping = 0;
  logic brownout_trip = 0, brownout_circuit_ready = 1, sw_pin_pullup = 0;
  logic global_irq_enable = 0, hwrite = 0, osc_done = 1, ext_reset_pin;
  rcc_pkg::rcc_cfg_s cfg = '{2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  rcc_pkg::rcc_req_s req = '0;
  logic [15:0] pc_current = 16'h0000, pc_load_value;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, x;
  logic [1:0]  htrans = 2'h0;
  logic hreadyout, hresp, core_reset, brownout_reset_enable, pc_load;
  logic irq_push, pin_pullup_enable, pin_gpio_value;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n;

  rcc_reset_ctrl #(.POWERUP_TIMER_CYCLES(PW)) u_dut (.sys_clk, .reset, .cfg, .req,
    .brownout_trip, .brownout_circuit_ready, .osc_startup_done(osc_done),
    .sleeping, .wake_irq, .global_irq_enable, .pc_current, .ext_reset_pin,
    .sw_pin_pullup, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .core_reset,
    .brownout_reset_enable, .pc_load, .pc_load_value, .irq_push,
    .pin_pullup_enable, .pin_gpio_value);
  rcc_pin_model u_pin (.sys_clk, .pull_low, .pullup_en(pin_pullup_enable),
    .pin(ext_reset_pin));

  // clock and hang guard
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one AHB-Lite single word transfer, entered right after an edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0, d);
    chk(d, {24'h0, e});
    chk(32'(hresp), 32'h0);
  endtask

  // cycles until the core leaves reset
  task automatic wait_run(output int k);
    for (k = 0; k < 300 && core_reset !== 1'b0; k++) @(posedge sys_clk);
    chk(32'(core_reset), 32'h0);
  endtask

  task automatic fire(input rcc_pkg::rcc_req_s r);
    req <= r;
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask

  task automatic pin_low(input int k);
    pull_low <= 1'b1;
    repeat (k) @(posedge sys_clk);
    pull_low <= 1'b0;
  endtask

  // expected brown-out protection for a mode, enable bit and sleep
  function automatic logic exp_bor(logic [1:0] m, logic sw, logic slp);
    case (m)
      rcc_pkg::BOR_MODE_ON:     return 1'b1;
      rcc_pkg::BOR_MODE_NSLEEP: return ~slp;
      rcc_pkg::BOR_MODE_SW:     return sw;
      default:                  return 1'b0;
    endcase
  endfunction

  // main sequence
  initial begin
    void'($urandom(32'h4b0bd07e));
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    wait_run(n);
    chk(32'(n >= PW), 32'h1);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h0C);
    rd_chk(rcc_pkg::OFF_STATUS, 8'h18);
    rd_chk(rcc_pkg::OFF_BOR_CTRL, 8'h81);
    rd_chk(8'h0C, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cfg.brownout_mode_config <= i[1:0];
      sleeping <= 1'($urandom);
      brownout_circuit_ready <= 1'($urandom);
      bus(1'b1, rcc_pkg::OFF_BOR_CTRL, {24'h0, i[2], 7'h7F}, d);
      rd_chk(rcc_pkg::OFF_BOR_CTRL,
             {i[2], 6'h0, brownout_circuit_ready});
      chk(32'(brownout_reset_enable),
          32'(exp_bor(i[1:0], i[2], sleeping)));
    end
    sleeping <= 1'b0;
    repeat (8) begin
      d = $urandom;
      bus(1'b1, rcc_pkg::OFF_PWR_CTRL, d, x);
      rd_chk(rcc_pkg::OFF_PWR_CTRL, d[7:0] & 8'hCF);
    end
    bus(1'b1, rcc_pkg::OFF_PWR_CTRL, 32'h0F, d);
    fire('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    chk({30'h0, core_reset, pc_load}, 32'h3);
    chk(32'(pc_load_value), 32'h0);
    wait_run(n);
    rd_chk(rcc_pkg::OFF_STATUS, 8'h08);
    fire('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
    wait_run(n);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h0B);
    bus(1'b1, rcc_pkg::OFF_PWR_CTRL, 32'h0F, d);
    cfg.stack_fault_reset_enable <= 1'b0;
    fire('{1'b0, 1'b0, 1'b1, 1'b1, 1'b0});
    @(posedge sys_clk);
    #1 chk(32'(core_reset), 32'h0);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h0F);
    cfg.stack_fault_reset_enable <= 1'b1;
    fire('{1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    wait_run(n);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h8F);
    fire('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    wait_run(n);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'hCF);
    rd_chk(rcc_pkg::OFF_STATUS, 8'h08);
    bus(1'b1, rcc_pkg::OFF_PWR_CTRL, 32'h0F, d);
    pin_low(5);
    repeat (15) @(posedge sys_clk);
    chk(32'(core_reset), 32'h0);
    pin_low(40);
    chk(32'(core_reset), 32'h1);
    wait_run(n);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h07);
    cfg.brownout_mode_config <= rcc_pkg::BOR_MODE_ON;
    bus(1'b1, rcc_pkg::OFF_PWR_CTRL, 32'h0F, d);
    bus(1'b1, rcc_pkg::OFF_BOR_CTRL, 32'h0, d);
    brownout_trip <= 1'b1;
    @(posedge sys_clk);
    brownout_trip <= 1'b0;
    #1;
    wait_run(n);
    chk(32'(n >= PW), 32'h1);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h0E);
    rd_chk(rcc_pkg::OFF_STATUS, 8'h18);
    rd_chk(rcc_pkg::OFF_BOR_CTRL, {7'h40, brownout_circuit_ready});
    bus(1'b1, rcc_pkg::OFF_PWR_CTRL, 32'h0F, d);
    fire('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    wait_run(n);
    chk(32'(n >= PW), 32'h1);
    rd_chk(rcc_pkg::OFF_PWR_CTRL, 8'h0C);
    osc_done <= 1'b0;
    fire('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    repeat (40) @(posedge sys_clk);
    chk(32'(core_reset), 32'h1);
    osc_done <= 1'b1;
    wait_run(n);
    fire('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1});
    pin_low(60);
    wait_run(n);
    chk(32'(n <= 14), 32'h1);
    sleeping <= 1'b1;
    pc_current <= 16'($urandom);
    fire('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    chk({core_reset, pc_load, pc_load_value},
        {2'h1, pc_current + 16'h1});
    rd_chk(rcc_pkg::OFF_STATUS, 8'h00);
    global_irq_enable <= 1'b1;
    wake_irq <= 1'b1;
    @(posedge sys_clk);
    wake_irq <= 1'b0;
    sleeping <= 1'b0;
    #1 chk({pc_load, pc_load_value}, {1'b1, pc_current + 16'h1});
    @(posedge sys_clk);
    #1 chk({irq_push, pc_load, pc_load_value}, {2'h3, 16'h0004});
    rd_chk(rcc_pkg::OFF_STATUS, 8'h10);
    sleeping <= 1'b1;
    fire('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0});
    pin_low(40);
    wait_run(n);
    rd_chk(rcc_pkg::OFF_STATUS, 8'h10);
    sleeping <= 1'b0;
    cfg.ext_reset_pin_enable <= 1'b0;
    sw_pin_pullup <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(pin_gpio_value), 32'h1);
    sw_pin_pullup <= 1'($urandom);
    pull_low <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(32'(core_reset), 32'h0);
    chk({pin_gpio_value, pin_pullup_enable}, {1'b0, sw_pin_pullup});
    cfg.low_voltage_prog_enable <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(32'(core_reset), 32'h1);
    pull_low <= 1'b0;
    wait_run(n);
    stop_test();
  end
endmodule

/* File: core/rcc_pkg.sv */
// constants, types and layouts for the reset control and cause logic
// assumes one 100 MHz clock and an AHB-Lite master with word accesses
// Behaviour
// - software brown-out enable always read/write; steers protection only in mode 01
// - control register bit 0 reads brown-out circuit active status
// - control bits 6..1 read zero; enable resets to 1 on power-on/brown-out only
// - pin reset disabled only when pin-enable and low-voltage-programming are both 0
// - enabled pin held low keeps device in reset; weak pull-up on
// - a filter rejects short pulses on the reset pin
// - no reset source drives the reset pin; it is input only
// - disabled pin is a general input with software-controlled pull-up
// - watchdog time-out resets device and clears the timeout flag; powerdown unchanged
// - reset instruction resets device and clears only the instruction flag
// - stack overflow/underflow resets only with stack fault reset enabled
// - leaving programming mode behaves exactly like power-on reset
// - after power-on/brown-out, wait for timer, oscillator and pin release
// - timers run while pin low; run at once on release if expired
// - power-on: PC 0000h, timeout and powerdown set, power flags 00 110x
// - brown-out: PC 0000h, timeout/powerdown set, power flags 00 11u0
// - pin reset clears pin flag; in sleep also sets timeout, clears powerdown
// - watchdog reset clears timeout; watchdog wake resumes PC+1, clears both
// - interrupt wake resumes PC+1, timeout set, powerdown clear; vector if enabled
// - overflow sets bit 7, underflow bit 6; restart at zero
// - unimplemented status bits read zero
// - power-up timer holds off execution after power-on or brown-out
// - power-up timer 64 ms, enabled by cleared bit, starts at the power-on/brown-out event
// - mode encoding: 11 on, 10 off in sleep, 01 software, 00 off
// - outside power-on/brown-out, hardware only sets stack flags, only clears pin/instruction flags
package rcc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_BOR_CTRL = 8'h00;
  localparam logic [7:0] OFF_PWR_CTRL = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;

  // field positions
  localparam int BIT_SW_BOR_EN  = 7;
  localparam int BIT_BOR_READY  = 0;
  localparam int BIT_STK_OVER   = 7;
  localparam int BIT_STK_UNDER  = 6;
  localparam int BIT_PIN_RST    = 3;
  localparam int BIT_INSTR_RST  = 2;
  localparam int BIT_POR        = 1;
  localparam int BIT_BOR        = 0;
  localparam int BIT_TIMEOUT    = 4;
  localparam int BIT_POWERDOWN  = 3;

  // power control: writable bits and power-on value 00 110x (x taken as 0)
  localparam logic [7:0] PWR_CTRL_MASK = 8'hCF;
  localparam logic [7:0] PWR_CTRL_POR  = 8'h0C;

  // brown-out mode encodings
  localparam logic [1:0] BOR_MODE_ON     = 2'h3;
  localparam logic [1:0] BOR_MODE_NSLEEP = 2'h2;
  localparam logic [1:0] BOR_MODE_SW     = 2'h1;
  localparam logic [1:0] BOR_MODE_OFF    = 2'h0;

  // program counter targets
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] PC_VECTOR  = 16'h0004;
  localparam logic [15:0] PC_STEP    = 16'h0001;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_TIMER_TIME_MS  = 64;
  localparam int POWERUP_TIMER_CYCLES   = POWERUP_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POWERUP_TIMER_W        = 23;
  localparam int FILT_TIME_NS  = 100;
  localparam int FILT_CYCLES   = FILT_TIME_NS / CLK_PERIOD_NS;
  localparam int FILT_W        = 4;

  // configuration word bits
  typedef struct packed {
    logic [1:0] brownout_mode_config;
    logic       ext_reset_pin_enable;
    logic       low_voltage_prog_enable;
    logic       stack_fault_reset_enable;
    logic       powerup_timer_enable_n;
    logic       osc_startup_needed;
  } rcc_cfg_s;

  // reset and wake requests from the core
  typedef struct packed {
    logic watchdog_timeout;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic prog_mode_exit;
  } rcc_req_s;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } rcc_state_e;

endpackage

/* File: core/rcc_reset_ctrl.sv */
// reset sequencing, reset-cause flags and brown-out control over AHB-Lite
// assumes synchronous inputs from core, analog detectors and the reset pin
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module rcc_reset_ctrl #(
  parameter int unsigned POWERUP_TIMER_CYCLES = rcc_pkg::POWERUP_TIMER_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire rcc_pkg::rcc_cfg_s cfg,
  input  wire rcc_pkg::rcc_req_s req,
  input  wire logic              brownout_trip,
  input  wire logic              brownout_circuit_ready,
  input  wire logic              osc_startup_done,
  input  wire logic              sleeping,
  input  wire logic              wake_irq,
  input  wire logic              global_irq_enable,
  input  wire logic [15:0]       pc_current,
  input  wire logic              ext_reset_pin,
  input  wire logic              sw_pin_pullup,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  output logic                   core_reset,
  output logic                   brownout_reset_enable,
  output logic                   pc_load,
  output logic [15:0]            pc_load_value,
  output logic                   irq_push,
  output logic                   pin_pullup_enable,
  output logic                   pin_gpio_value
);

  // ---------------- register state ----------------
  logic                  sw_brownout_enable;
  logic [7:0]            power_ctrl_reg;
  logic                  timeout_flag;
  logic                  powerdown_flag;
  rcc_pkg::rcc_state_e   state;
  logic [rcc_pkg::POWERUP_TIMER_W-1:0] powerup_timer_cnt;
  logic                  ost_ok;
  logic                  por_pend;
  logic                  pin_filt;
  logic [rcc_pkg::FILT_W-1:0] filt_cnt;
  logic                  pin_rst_d;
  logic                  vec_pend;
  logic                  a_wr;
  logic [7:0]            a_addr;
  logic [15:0]           ret_addr;

  // ---------------- bus decode ----------------
  wire        bus_take = hsel & htrans[1] & hready;
  wire [7:0]  b_addr   = haddr[7:0];
  wire        addr_hit = (haddr[31:8] == 24'h000000);
  wire        wr_ctrl  = a_wr & (a_addr == rcc_pkg::OFF_BOR_CTRL);
  wire        wr_power_ctrl_reg  = a_wr & (a_addr == rcc_pkg::OFF_PWR_CTRL);

  // read images; unimplemented bits are zero
  wire [7:0] ctrl_img = {sw_brownout_enable, 6'h00,
                         brownout_circuit_ready};
  wire [7:0] stat_img = {3'h0, timeout_flag, powerdown_flag, 3'h0};
  wire [7:0] rd_byte  =
    !addr_hit ? 8'h00 :
    (b_addr == rcc_pkg::OFF_BOR_CTRL) ? ctrl_img :
    (b_addr == rcc_pkg::OFF_PWR_CTRL) ? power_ctrl_reg :
    (b_addr == rcc_pkg::OFF_STATUS)   ? stat_img : 8'h00;

  // ---------------- brown-out mode ----------------
  wire mode_sw  = (cfg.brownout_mode_config == rcc_pkg::BOR_MODE_SW);
  wire mode_on  = (cfg.brownout_mode_config == rcc_pkg::BOR_MODE_ON);
  wire mode_ns  = (cfg.brownout_mode_config == rcc_pkg::BOR_MODE_NSLEEP);
  wire next_bor_en = mode_on | (mode_ns & ~sleeping)
                   | (mode_sw & sw_brownout_enable);
  wire bor_evt  = brownout_trip & brownout_reset_enable;

  // ---------------- reset pin ----------------
  wire pin_en   = cfg.ext_reset_pin_enable
                | cfg.low_voltage_prog_enable;
  wire pin_rst  = pin_en & ~pin_filt;
  wire pin_evt  = pin_rst & ~pin_rst_d;
  wire filt_dif = (ext_reset_pin != pin_filt);
  wire filt_end = (filt_cnt == rcc_pkg::FILT_W'(rcc_pkg::FILT_CYCLES - 1));

  // ---------------- request merge ----------------
  wire por_evt  = por_pend | req.prog_mode_exit;
  wire wdt_rst  = req.watchdog_timeout & ~sleeping;
  wire wdt_wake = req.watchdog_timeout & sleeping;
  wire irq_wake = wake_irq & sleeping & ~req.watchdog_timeout;
  wire stk_ovf  = req.stack_over & cfg.stack_fault_reset_enable;
  wire stk_unf  = req.stack_under & cfg.stack_fault_reset_enable;
  wire any_rst  = por_evt | bor_evt | pin_evt | wdt_rst
                | req.reset_instr | stk_ovf | stk_unf;
  wire cold     = por_evt | bor_evt;
  wire powerup_timer_run = (powerup_timer_cnt != '0);
  wire ost_ready = ost_ok | ~cfg.osc_startup_needed;
  wire can_run  = ~powerup_timer_run & ost_ready & ~pin_rst & ~bor_evt;

  // ---------------- next flag values ----------------
  logic [7:0] next_power_ctrl_reg;
  logic       next_to;
  logic       next_pd;

  // firmware write first; hardware events override so the event's set or clear wins
  always_comb begin
    next_power_ctrl_reg = power_ctrl_reg;
    next_to   = timeout_flag;
    next_pd   = powerdown_flag;
    if (wr_power_ctrl_reg) begin
      next_power_ctrl_reg = hwdata[7:0] & rcc_pkg::PWR_CTRL_MASK;
    end
    if (por_evt) begin
      next_power_ctrl_reg = rcc_pkg::PWR_CTRL_POR;
      next_to   = 1'b1;
      next_pd   = 1'b1;
    end else if (bor_evt) begin
      next_power_ctrl_reg[rcc_pkg::BIT_STK_OVER]  = 1'b0;
      next_power_ctrl_reg[rcc_pkg::BIT_STK_UNDER] = 1'b0;
      next_power_ctrl_reg[rcc_pkg::BIT_PIN_RST]   = 1'b1;
      next_power_ctrl_reg[rcc_pkg::BIT_INSTR_RST] = 1'b1;
      next_power_ctrl_reg[rcc_pkg::BIT_BOR]       = 1'b0;
      next_to   = 1'b1;
      next_pd   = 1'b1;
    end else begin
      if (pin_evt) begin
        next_power_ctrl_reg[rcc_pkg::BIT_PIN_RST] = 1'b0;
        if (sleeping) begin
          next_to = 1'b1;
          next_pd = 1'b0;
        end
      end
      if (wdt_rst) begin
        next_to = 1'b0;
      end
      if (wdt_wake) begin
        next_to = 1'b0;
        next_pd = 1'b0;
      end
      if (irq_wake) begin
        next_to = 1'b1;
        next_pd = 1'b0;
      end
      if (req.reset_instr) begin
        next_power_ctrl_reg[rcc_pkg::BIT_INSTR_RST] = 1'b0;
      end
      if (stk_ovf) begin
        next_power_ctrl_reg[rcc_pkg::BIT_STK_OVER] = 1'b1;
      end
      if (stk_unf) begin
        next_power_ctrl_reg[rcc_pkg::BIT_STK_UNDER] = 1'b1;
      end
    end
  end

  // ---------------- sequencer ----------------
  wire rcc_pkg::rcc_state_e next_state =
    any_rst ? rcc_pkg::ST_HOLD :
    (state == rcc_pkg::ST_HOLD && can_run) ? rcc_pkg::ST_RUN : state;
  wire [rcc_pkg::POWERUP_TIMER_W-1:0] next_powerup_timer =
    (cold && !cfg.powerup_timer_enable_n) ?
      rcc_pkg::POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES) :
    cold ? '0 :
    powerup_timer_run ? powerup_timer_cnt - rcc_pkg::POWERUP_TIMER_W'(1) : powerup_timer_cnt;
  wire next_ost = (cold & cfg.osc_startup_needed) ? 1'b0 :
                  (ost_ok | osc_startup_done);

  // ---------------- bus slave flops ----------------
  // zero wait states; read image captured in the address phase
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      a_wr      <= 1'b0;
      a_addr    <= '0;
    end else begin
      a_wr   <= bus_take & hwrite & addr_hit;
      a_addr <= b_addr;
      if (bus_take && !hwrite) begin
        hrdata <= {24'h000000, rd_byte};
      end
    end
  end

  // ---------------- software brown-out enable ----------------
  // survives every reset except power-on and brown-out
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sw_brownout_enable <= 1'b1;
    end else if (cold) begin
      sw_brownout_enable <= 1'b1;
    end else if (wr_ctrl) begin
      sw_brownout_enable <= hwdata[rcc_pkg::BIT_SW_BOR_EN];
    end
  end

  // ---------------- cause flags ----------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_ctrl_reg <= rcc_pkg::PWR_CTRL_POR;
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else begin
      power_ctrl_reg <= next_power_ctrl_reg;
      timeout_flag   <= next_to;
      powerdown_flag <= next_pd;
    end
  end

  // ---------------- pin filter ----------------
  // level must stand FILT_CYCLES before it is believed
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_filt  <= 1'b1;
      filt_cnt  <= '0;
      pin_rst_d <= 1'b0;
    end else begin
      pin_rst_d <= pin_rst;
      if (!filt_dif) begin
        filt_cnt <= '0;
      end else if (filt_end) begin
        filt_cnt <= '0;
        pin_filt <= ext_reset_pin;
      end else begin
        filt_cnt <= filt_cnt + rcc_pkg::FILT_W'(1);
      end
    end
  end

  // ---------------- timers and state ----------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state    <= rcc_pkg::ST_HOLD;
      powerup_timer_cnt <= '0;
      ost_ok   <= 1'b0;
      por_pend <= 1'b1;
    end else begin
      state    <= next_state;
      powerup_timer_cnt <= next_powerup_timer;
      ost_ok   <= next_ost;
      por_pend <= 1'b0;
    end
  end

  // ---------------- outputs to core and pad ----------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_reset            <= 1'b1;
      brownout_reset_enable <= 1'b0;
      pc_load               <= 1'b0;
      pc_load_value         <= rcc_pkg::PC_RESET;
      irq_push              <= 1'b0;
      vec_pend              <= 1'b0;
      ret_addr              <= rcc_pkg::PC_RESET;
      pin_pullup_enable     <= 1'b1;
      pin_gpio_value        <= 1'b0;
    end else begin
      core_reset            <= (next_state == rcc_pkg::ST_HOLD);
      brownout_reset_enable <= next_bor_en;
      pin_pullup_enable     <= pin_en | sw_pin_pullup;
      pin_gpio_value        <= pin_en ? 1'b0 : ext_reset_pin;
      irq_push              <= 1'b0;
      pc_load               <= 1'b0;
      vec_pend              <= 1'b0;
      if (any_rst) begin
        pc_load       <= 1'b1;
        pc_load_value <= rcc_pkg::PC_RESET;
      end else if (wdt_wake || irq_wake) begin
        pc_load       <= 1'b1;
        pc_load_value <= pc_current + rcc_pkg::PC_STEP;
        ret_addr      <= pc_current + rcc_pkg::PC_STEP;
        vec_pend      <= irq_wake & global_irq_enable;
      end else if (vec_pend) begin
        pc_load       <= 1'b1;
        pc_load_value <= rcc_pkg::PC_VECTOR;
        irq_push      <= 1'b1;
      end
    end
  end

  // ---------------- checks ----------------
  chk_sw_enable_gate: assert property (@(posedge sys_clk) disable iff (reset)
    mode_sw |=> brownout_reset_enable == $past(sw_brownout_enable))
    else $error("software enable not steering brown-out");
  chk_mode_off: assert property (@(posedge sys_clk) disable iff (reset)
    (cfg.brownout_mode_config == rcc_pkg::BOR_MODE_OFF)
    |=> !brownout_reset_enable)
    else $error("brown-out enabled in off mode");
  chk_ready_readback: assert property (@(posedge sys_clk) disable iff (reset)
    bus_take && !hwrite && haddr == 32'(rcc_pkg::OFF_BOR_CTRL)
    |=> hrdata[7:0] == {$past(sw_brownout_enable), 6'h00,
                        $past(brownout_circuit_ready)})
    else $error("control readback wrong");
  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
    hrdata[31:8] == 24'h000000 && power_ctrl_reg[5:4] == 2'h0)
    else $error("unimplemented bits not zero");
  chk_pin_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    !cfg.ext_reset_pin_enable && !cfg.low_voltage_prog_enable
    |-> !pin_rst)
    else $error("pin reset while disabled");
  chk_pin_hold: assert property (@(posedge sys_clk) disable iff (reset)
    pin_rst |=> core_reset)
    else $error("pin low without reset");
  chk_filter_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    $changed(pin_filt) |-> $past(filt_dif) && $past(filt_end))
    else $error("filter passed short pulse");
  chk_wdt_flag: assert property (@(posedge sys_clk) disable iff (reset)
    wdt_rst && !cold |=> !timeout_flag && core_reset)
    else $error("watchdog reset not marked");
  chk_instr_flag: assert property (@(posedge sys_clk) disable iff (reset)
    req.reset_instr && !cold |=>
      !power_ctrl_reg[rcc_pkg::BIT_INSTR_RST] && core_reset)
    else $error("instruction reset not marked");
  chk_stack_gate: assert property (@(posedge sys_clk) disable iff (reset)
    req.stack_over && !cfg.stack_fault_reset_enable && !pin_rst
    && !any_rst && state == rcc_pkg::ST_RUN |=> !core_reset)
    else $error("stack fault reset while disabled");
  chk_por_image: assert property (@(posedge sys_clk) disable iff (reset)
    por_evt |=> power_ctrl_reg == rcc_pkg::PWR_CTRL_POR
      && timeout_flag && powerdown_flag && pc_load
      && pc_load_value == rcc_pkg::PC_RESET)
    else $error("power-on image wrong");
  chk_powerup_timer_hold: assert property (@(posedge sys_clk) disable iff (reset)
    powerup_timer_run |=> core_reset)
    else $error("ran before power-up timer expired");
  chk_pin_release: assert property (@(posedge sys_clk) disable iff (reset)
    state == rcc_pkg::ST_HOLD && can_run && !any_rst
    |=> !core_reset)
    else $error("no immediate start on pin release");
  chk_irq_vector: assert property (@(posedge sys_clk) disable iff (reset)
    irq_wake && global_irq_enable && !any_rst |=> pc_load
      ##1 irq_push && pc_load_value == rcc_pkg::PC_VECTOR)
    else $error("interrupt wake vector missing");
  chk_stack_flag: assert property (@(posedge sys_clk) disable iff (reset)
    stk_ovf && !cold
    |=> power_ctrl_reg[rcc_pkg::BIT_STK_OVER] && core_reset)
    else $error("overflow reset not marked");
  chk_pin_sleep: assert property (@(posedge sys_clk) disable iff (reset)
    pin_evt && sleeping && !cold && !req.watchdog_timeout
    |=> timeout_flag && !powerdown_flag
      && !power_ctrl_reg[rcc_pkg::BIT_PIN_RST])
    else $error("pin reset in sleep not marked");
  chk_bor_image: assert property (@(posedge sys_clk) disable iff (reset)
    bor_evt && !por_evt |=> power_ctrl_reg[rcc_pkg::BIT_PIN_RST]
      && power_ctrl_reg[rcc_pkg::BIT_INSTR_RST]
      && !power_ctrl_reg[rcc_pkg::BIT_BOR] && timeout_flag && pc_load)
    else $error("brown-out image wrong");
  chk_wdt_wake: assert property (@(posedge sys_clk) disable iff (reset)
    wdt_wake && !any_rst |=> !timeout_flag && !powerdown_flag && pc_load
      && pc_load_value == $past(pc_current) + rcc_pkg::PC_STEP)
    else $error("watchdog wake not resumed");
  chk_sw_enable_cold: assert property (@(posedge sys_clk) disable iff (reset)
    cold |=> sw_brownout_enable)
    else $error("software enable not restored");
  chk_ost_hold: assert property (@(posedge sys_clk) disable iff (reset)
    cfg.osc_startup_needed && !ost_ok && state == rcc_pkg::ST_HOLD
    |=> core_reset)
    else $error("ran before oscillator start-up");

  cov_pin_reset: cover property (@(posedge sys_clk) disable iff (reset)
    pin_evt ##[1:20] !core_reset);
  cov_wdt_wake: cover property (@(posedge sys_clk) disable iff (reset)
    wdt_wake);
  cov_brownout: cover property (@(posedge sys_clk) disable iff (reset)
    bor_evt ##1 !bor_evt);
  cov_irq_vector: cover property (@(posedge sys_clk) disable iff (reset)
    irq_push);

endmodule
